// ==== src_top.sv ====
// System reset, brown-out, boot and vector-map control with APB registers
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module src_top
    import src_pkg::*;
#(
    parameter int WAKE_CYCLES = SRC_WAKE_CYCLES,
    parameter int NUM_EXTINT  = SRC_NUM_EXTINT
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata,
    // Reset sources
    input  wire logic                  ext_reset_n,
    input  wire logic                  wdt_reset,
    input  wire logic                  por_detect,
    input  wire logic                  osc_running,
    // Brown-out comparators
    input  wire logic                  bod_stage1,
    input  wire logic                  bod_stage2,
    // Wake-up and power-down
    input  wire logic [NUM_EXTINT-1:0] ext_irq,
    input  wire logic                  boot_done,
    // Resets and interrupt out
    output logic                       chip_reset_n,
    output logic                       brownout_detector_irq,
    output logic                       brownout_detector_reset,
    output logic                       wakeup,
    // Boot memory setup
    output var  logic                  booting,
    output logic [31:0]                boot_addr,
    output logic [1:0]                 boot_bank,
    output logic [5:0]                 boot_data_width,
    output logic [5:0]                 boot_addr_lines,
    // Vector map and clocking
    output var  logic [1:0]            vector_map,
    output var  logic [1:0]            clk_source,
    output var  logic                  mul_enable,
    output var  logic                  mul_connect,
    output var  logic                  power_down
);
    // ------------------------------------------------------------
    // Reset merge
    // ------------------------------------------------------------
    logic                      bor_en_q;
    logic                      raw_rst_n;
    logic                      int_rst_n;
    logic                      bor_active;

    // Brown-out reset follows bod_stage2 alone; it does not hold on until power-on detection covers
    assign brownout_detector_reset = bod_stage2 | (bod_stage2 & por_detect);
    assign bor_active = brownout_detector_reset & bor_en_q;
    // Enable register lives under presetn so a brown-out reset keeps it
    assign raw_rst_n = presetn & ext_reset_n & ~wdt_reset & ~por_detect
                     & ~bor_active;

    src_rst_sync u_sync (
        .pclk       (pclk),
        .raw_rst_n  (raw_rst_n),
        .sync_rst_n (int_rst_n)
    );

    // ------------------------------------------------------------
    // Wake-up timer and sequencing
    // ------------------------------------------------------------
    src_state_type             state_q;
    src_state_type             state_d;
    logic [SRC_WAKE_CNT_W-1:0] wake_cnt_q;
    logic                      wake_done;
    logic                      pd_q;
    logic                      pd_wake_q;
    logic                      wake_req;
    logic                      wake_sel;
    logic [NUM_EXTINT-1:0]     wake_en_q;

    assign wake_done = wake_cnt_q >= SRC_WAKE_CNT_W'(WAKE_CYCLES - 1);
    assign wake_req  = |ext_irq;
    // Only enabled lines may end power-down
    assign wake_sel  = |(ext_irq & wake_en_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            SRC_ST_RESET: state_d = SRC_ST_WAKE;
            // Release waits on pin, oscillator and count
            SRC_ST_WAKE:  if (wake_done && osc_running && ext_reset_n) begin
                state_d = pd_wake_q ? SRC_ST_RUN : SRC_ST_BOOT;
            end
            SRC_ST_BOOT:  if (boot_done) begin
                state_d = SRC_ST_RUN;
            end
            SRC_ST_RUN:   if (pd_q && wake_sel) begin
                state_d = SRC_ST_WAKE;
            end
            default:      state_d = SRC_ST_RESET;
        endcase
    end

    // Power-down wake reruns the timer but keeps chip reset off and skips boot
    always_ff @(posedge pclk or negedge int_rst_n) begin
        if (!int_rst_n) begin
            state_q    <= SRC_ST_RESET;
            wake_cnt_q <= '0;
            pd_wake_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == SRC_ST_RUN && state_d == SRC_ST_WAKE) begin
                pd_wake_q <= 1'b1;
            end else if (state_q == SRC_ST_WAKE && state_d != SRC_ST_WAKE) begin
                pd_wake_q <= 1'b0;
            end
            if (state_q == SRC_ST_WAKE && !wake_done) begin
                wake_cnt_q <= wake_cnt_q + 1'b1;
            end else if (state_d == SRC_ST_WAKE && state_q != SRC_ST_WAKE) begin
                wake_cnt_q <= '0;
            end
        end
    end

    // Chip reset released once the timer sequence is past; a power-down wake keeps it released
    assign chip_reset_n = int_rst_n & (state_q == SRC_ST_BOOT || state_q == SRC_ST_RUN ||
                          (state_q == SRC_ST_WAKE && pd_wake_q));
    assign wakeup       = pd_q & wake_req;

    // ------------------------------------------------------------
    // Boot outputs
    // ------------------------------------------------------------
    assign booting         = chip_reset_n & (state_q == SRC_ST_BOOT);
    assign boot_addr       = SRC_BOOT_ADDR;
    assign boot_bank       = SRC_BOOT_BANK;
    assign boot_data_width = SRC_BOOT_DWIDTH;
    assign boot_addr_lines = SRC_BOOT_ALINES;

    // ------------------------------------------------------------
    // Brown-out interrupt
    // ------------------------------------------------------------
    // Raw level goes out; the irq controller applies its own enable
    assign brownout_detector_irq = bod_stage1;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic                  wr_en;
    logic                  rd_en;
    logic                  hit_ctrl;
    logic                  hit_stat;
    logic                  hit_vmap;
    logic                  hit_clk;
    logic                  hit_wake;
    logic                  hit_boot;
    logic                  hit_pd;
    logic                  hit_any;
    logic [31:0]           rd_mux;
    logic [7:0]            status;
    logic                  ext_seen_q;
    logic                  wdt_seen_q;
    logic                  por_seen_q;
    logic                  bor_seen_q;

    assign wr_en    = psel & penable & pwrite;
    assign rd_en    = psel & ~penable & ~pwrite;
    assign hit_ctrl = paddr == SRC_CTRL_OFS;
    assign hit_stat = paddr == SRC_STAT_OFS;
    assign hit_vmap = paddr == SRC_VMAP_OFS;
    assign hit_clk  = paddr == SRC_CLK_OFS;
    assign hit_wake = paddr == SRC_WAKE_OFS;
    assign hit_boot = paddr == SRC_BOOT_OFS;
    assign hit_pd   = paddr == SRC_PD_OFS;
    assign hit_any  = hit_ctrl | hit_stat | hit_vmap | hit_clk | hit_wake | hit_boot | hit_pd;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~hit_any;

    assign status = {pd_q, booting, bor_seen_q, wdt_seen_q, ext_seen_q, por_seen_q,
                     brownout_detector_reset, bod_stage1};

    assign rd_mux = hit_ctrl ? {31'h0, bor_en_q} :
                    hit_stat ? {24'h0, status} :
                    hit_vmap ? {30'h0, vector_map} :
                    hit_clk  ? {28'h0, mul_connect, mul_enable, clk_source} :
                    hit_wake ? {{(32-NUM_EXTINT){1'b0}}, wake_en_q} :
                    hit_boot ? SRC_BOOT_ADDR :
                    hit_pd   ? {31'h0, pd_q} : 32'h0;

    // Sticky cause flags survive chip reset; cleared by write of one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bor_en_q   <= 1'b0;
            ext_seen_q <= 1'b0;
            wdt_seen_q <= 1'b0;
            por_seen_q <= 1'b1;
            bor_seen_q <= 1'b0;
            prdata     <= 32'h0;
        end else begin
            ext_seen_q <= ~ext_reset_n | (ext_seen_q &
                          ~(wr_en & hit_stat & pwdata[SRC_STAT_EXT]));
            wdt_seen_q <= wdt_reset | (wdt_seen_q &
                          ~(wr_en & hit_stat & pwdata[SRC_STAT_WDT]));
            por_seen_q <= por_detect | (por_seen_q &
                          ~(wr_en & hit_stat & pwdata[SRC_STAT_POR]));
            bor_seen_q <= bor_active | (bor_seen_q &
                          ~(wr_en & hit_stat & pwdata[SRC_STAT_BOR]));
            if (wr_en && hit_ctrl) begin
                bor_en_q <= pwdata[SRC_CTRL_BOR_EN_BIT];
            end
            if (rd_en) begin
                prdata <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers set to their defaults by chip reset
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge int_rst_n) begin
        if (!int_rst_n) begin
            vector_map  <= SRC_VMAP_EXT;
            clk_source  <= SRC_CLK_IRC;
            mul_enable  <= 1'b0;
            mul_connect <= 1'b0;
            wake_en_q   <= '0;
            pd_q        <= 1'b0;
        end else begin
            if (wr_en && hit_vmap && pwdata[1:0] != 2'h3) begin
                vector_map <= pwdata[1:0];
            end
            if (wr_en && hit_clk) begin
                clk_source  <= pwdata[SRC_CLK_SEL_LSB +: 2];
                mul_enable  <= pwdata[SRC_CLK_MUL_EN_BIT];
                mul_connect <= pwdata[SRC_CLK_MUL_CON_BIT] & pwdata[SRC_CLK_MUL_EN_BIT];
            end
            if (wr_en && hit_wake) begin
                wake_en_q <= pwdata[NUM_EXTINT-1:0];
            end
            if (|(ext_irq & wake_en_q)) begin
                pd_q <= 1'b0;
            end else if (wr_en && hit_pd) begin
                pd_q <= pwdata[0];
            end
        end
    end

    assign power_down = pd_q;

endmodule : src_top
`default_nettype wire

// ==== src_pkg.sv ====
// Constants, register map and types of the system reset and boot control block
// How it works
// - Chip reset asserts while pin, watchdog, power-on or enabled brown-out reset is active.
// - Any reset restarts wake-up timer; release needs pin released, oscillator up, count done.
// - After internal reset release all registers hold defined values; boot from external memory.
// - First fetch always from static bank 1 at the fixed boot address.
// - During boot the memory controller uses 16-bit data and 24 address lines.
// - First-stage brown-out comparator drives the interrupt line to the irq controller.
// - First stage interrupts only if enabled there; otherwise readable in a status register.
// - Second-stage comparator asserts brown-out reset; chip reset only when software enables it.
// - Brown-out reset follows the second-stage comparator alone; it does not hold until power-on detection takes over.
// - Enabled external interrupt inputs end power-down; the wakeup output flags any of them while powered down.
// - Vector map selects boot ROM, SRAM or external memory for the region at zero.
// - After reset vectors map to external memory; software remaps after boot.
// - After any chip reset the clock source is the internal RC oscillator.
// - Chip reset turns off and bypasses the clock multiplier until software enables it.
package src_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] SRC_CTRL_OFS   = 12'h000;
    localparam logic [11:0] SRC_STAT_OFS   = 12'h004;
    localparam logic [11:0] SRC_VMAP_OFS   = 12'h008;
    localparam logic [11:0] SRC_CLK_OFS    = 12'h00c;
    localparam logic [11:0] SRC_WAKE_OFS   = 12'h010;
    localparam logic [11:0] SRC_BOOT_OFS   = 12'h014;
    localparam logic [11:0] SRC_PD_OFS     = 12'h018;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SRC_CTRL_BOR_EN_BIT = 0;
    localparam int SRC_STAT_BOD_INT    = 0;
    localparam int SRC_STAT_BOD_RST    = 1;
    localparam int SRC_STAT_POR        = 2;
    localparam int SRC_STAT_EXT        = 3;
    localparam int SRC_STAT_WDT        = 4;
    localparam int SRC_STAT_BOR        = 5;
    localparam int SRC_STAT_BOOTING    = 6;
    localparam int SRC_STAT_PD         = 7;
    localparam int SRC_CLK_SEL_LSB     = 0;
    localparam int SRC_CLK_MUL_EN_BIT  = 2;
    localparam int SRC_CLK_MUL_CON_BIT = 3;

    // ------------------------------------------------------------
    // Reset values and interrupt count
    // ------------------------------------------------------------
    localparam logic [31:0] SRC_BOOT_ADDR     = 32'h8100_0000;
    localparam logic [1:0]  SRC_BOOT_BANK     = 2'h1;
    localparam logic [5:0]  SRC_BOOT_DWIDTH   = 6'h10;
    localparam logic [5:0]  SRC_BOOT_ALINES   = 6'h18;
    localparam logic [31:0] SRC_VECTOR_BASE   = 32'h0000_0000;
    localparam int          SRC_NUM_EXTINT    = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SRC_CLK_MHZ        = 250;
    localparam int SRC_WAKE_CYCLES    = 4096;
    localparam int SRC_WAKE_CNT_W     = 13;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_VMAP_ROM  = 2'h0,
        SRC_VMAP_SRAM = 2'h1,
        SRC_VMAP_EXT  = 2'h2
    } src_vmap_type;

    typedef enum logic [1:0] {
        SRC_CLK_IRC  = 2'h0,
        SRC_CLK_MAIN = 2'h1,
        SRC_CLK_RTC  = 2'h2
    } src_clk_type;

    // Gray order along the usual path
    typedef enum logic [1:0] {
        SRC_ST_RESET = 2'b00,
        SRC_ST_WAKE  = 2'b01,
        SRC_ST_BOOT  = 2'b11,
        SRC_ST_RUN   = 2'b10
    } src_state_type;

endpackage : src_pkg

// ==== src_rst_sync.sv ====
// Reset synchroniser: asynchronous assert, clocked release
`timescale 1ns/1ns
`default_nettype none
module src_rst_sync (
    // Clock and raw reset
    input  wire logic pclk,
    input  wire logic raw_rst_n,
    // Synchronised reset
    output var  logic sync_rst_n
);
    logic meta_q;

    // Only the second stage is seen outside
    always_ff @(posedge pclk or negedge raw_rst_n) begin
        if (!raw_rst_n) begin
            meta_q     <= 1'b0;
            sync_rst_n <= 1'b0;
        end else begin
            meta_q     <= 1'b1;
            sync_rst_n <= meta_q;
        end
    end
endmodule : src_rst_sync
`default_nettype wire

// ==== src_top_asserts.sv ====
// Concurrent checks on the ports of the system reset and boot control block
`timescale 1ns/1ns
`default_nettype none
module src_top_asserts #(
    parameter int WAKE_CYCLES = 8,
    parameter int NUM_EXTINT  = 4
) (
    // Clock, reset and inputs
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  ext_reset_n,
    input wire logic                  wdt_reset,
    input wire logic                  por_detect,
    input wire logic                  osc_running,
    input wire logic                  bod_stage1,
    input wire logic                  bod_stage2,
    input wire logic [NUM_EXTINT-1:0] ext_irq,
    // Outputs
    input wire logic                  chip_reset_n,
    input wire logic                  brownout_detector_irq,
    input wire logic                  brownout_detector_reset,
    input wire logic                  wakeup,
    input wire logic [31:0]           boot_addr,
    input wire logic [1:0]            boot_bank,
    input wire logic [5:0]            boot_data_width,
    input wire logic [5:0]            boot_addr_lines,
    input wire logic [1:0]            vector_map,
    input wire logic                  mul_enable,
    input wire logic                  mul_connect,
    input wire logic                  power_down
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Helper: length of the current chip reset
    // ------------------------------------------------------------
    logic [15:0] low_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_q <= 16'h0;
        else if (chip_reset_n) low_q <= 16'h0;
        else if (low_q != 16'hffff) low_q <= low_q + 16'h1;
    end
    sequence s_rel;
        !chip_reset_n [*2];
    endsequence
    property p_src;  (!ext_reset_n || wdt_reset || por_detect) |-> !chip_reset_n; endproperty
    property p_wake;
        $rose(chip_reset_n) |-> low_q >= WAKE_CYCLES && $past(osc_running) && $past(ext_reset_n);
    endproperty
    property p_rel;  $rose(presetn) |-> s_rel; endproperty
    property p_boot; boot_addr == 32'h8100_0000 && boot_bank == 2'h1; endproperty
    property p_bus;  boot_data_width == 6'h10 && boot_addr_lines == 6'h18; endproperty
    property p_irq;  brownout_detector_irq == bod_stage1; endproperty
    property p_bor;  brownout_detector_reset == bod_stage2; endproperty
    property p_wkup; wakeup == (power_down && (|ext_irq)); endproperty
    property p_vmap; vector_map != 2'h3; endproperty
    property p_mul;  mul_connect |-> mul_enable; endproperty
    a_src:  assert property (p_src)  else $error("chip reset missing for active source");
    a_wake: assert property (p_wake) else $error("chip reset released too early");
    a_rel:  assert property (p_rel)  else $error("reset release not synchronised");
    a_boot: assert property (p_boot) else $error("boot address or bank wrong");
    a_bus:  assert property (p_bus)  else $error("boot bus widths wrong");
    a_irq:  assert property (p_irq)  else $error("brown-out irq not following stage 1");
    a_bor:  assert property (p_bor)  else $error("brown-out reset not following stage 2");
    a_wkup: assert property (p_wkup) else $error("wakeup not from power-down irq");
    a_vmap: assert property (p_vmap) else $error("vector map illegal value");
    a_mul:  assert property (p_mul)  else $error("multiplier connected while off");
endmodule : src_top_asserts
`default_nettype wire

// ==== src_boot_model.sv ====
// Boot-side partner: ends the boot phase a fixed time after it starts
`timescale 1ns/1ns
`default_nettype none
module src_boot_model #(
    parameter int BOOT_LAT = 6
) (
    // Clock and chip reset
    input  wire logic pclk,
    input  wire logic chip_reset_n,
    // Boot handshake
    input  wire logic booting,
    output var  logic boot_done
);
    logic [7:0] cnt_q;
    // Chip reset aborts a boot in progress
    always_ff @(posedge pclk or negedge chip_reset_n) begin
        if (!chip_reset_n) begin
            cnt_q     <= 8'h0;
            boot_done <= 1'b0;
        end else begin
            if (booting && cnt_q != BOOT_LAT[7:0]) cnt_q <= cnt_q + 8'h1;
            if (!booting) cnt_q <= 8'h0;
            boot_done <= booting && cnt_q == BOOT_LAT[7:0];
        end
    end
endmodule : src_boot_model
`default_nettype wire

// ==== src_top_tb.sv ====
// Self-checking testbench of the system reset and boot control block
`timescale 1ns/1ns
`default_nettype none
module src_top_tb;
    import src_pkg::*;
    localparam int WAKE_CYCLES = 8;
    localparam int NUM_EXTINT  = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, boot_addr, r;
    logic        ext_reset_n, wdt_reset, por_detect, osc_running, bod_stage1, bod_stage2;
    logic [3:0]  ext_irq;
    logic        boot_done, chip_reset_n, brownout_detector_irq, brownout_detector_reset;
    logic        wakeup, booting, mul_enable, mul_connect, power_down, e;
    logic [1:0]  boot_bank, vector_map, clk_source;
    logic [5:0]  boot_data_width, boot_addr_lines;
    int          bad_count, checks_done;
    src_top #(.WAKE_CYCLES(WAKE_CYCLES), .NUM_EXTINT(NUM_EXTINT)) DUT (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .ext_reset_n,
        .wdt_reset, .por_detect, .osc_running, .bod_stage1, .bod_stage2, .ext_irq, .boot_done,
        .chip_reset_n, .brownout_detector_irq, .brownout_detector_reset, .wakeup, .booting,
        .boot_addr, .boot_bank, .boot_data_width, .boot_addr_lines, .vector_map, .clk_source,
        .mul_enable, .mul_connect, .power_down);
    src_boot_model #(.BOOT_LAT(6)) u_boot (.pclk, .chip_reset_n, .booting, .boot_done);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // APB master: no fixed wait assumed, bounded by a count
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("pready", pready, 1'b1);
            results();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wait_lvl(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 300) begin @(posedge pclk); n++; end
        if (n >= 300) begin
            bad_count++;
            results();
        end
        #1;
    endtask : wait_lvl
    task automatic t_boot();
        wait_lvl(chip_reset_n, 1'b1);
        chk("booting", booting, 1'b1);
        chk("vector_map", vector_map, 2'h2);
        chk("clk_source", clk_source, 2'h0);
        chk("mul", {mul_enable, mul_connect}, 2'h0);
        chk("boot_addr", boot_addr, 32'h8100_0000);
        chk("boot_bank", boot_bank, 2'h1);
        chk("boot_bus", {boot_data_width, boot_addr_lines}, {6'h10, 6'h18});
        apb(1'b0, SRC_BOOT_OFS, 32'h0);
        chk("boot_reg", r, 32'h8100_0000);
        wait_lvl(booting, 1'b0);
        chk("boot_end", booting, 1'b0);
    endtask : t_boot
    task automatic t_sources();
        apb(1'b1, SRC_STAT_OFS, 32'h3c);
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            osc_running <= 1'b0; wdt_reset <= (i == 2); por_detect <= (i == 0);
            ext_reset_n <= (i != 1);
            #1 chk("src_rst", chip_reset_n, 1'b0);
            @(posedge pclk);
            wdt_reset <= 1'b0; por_detect <= 1'b0; ext_reset_n <= 1'b1;
            repeat (WAKE_CYCLES * 3) @(posedge pclk);
            chk("osc_hold", chip_reset_n, 1'b0);
            osc_running <= 1'b1;
            wait_lvl(chip_reset_n, 1'b1);
            apb(1'b0, SRC_STAT_OFS, 32'h0);
            chk("stat_seen", r[2+i], 1'b1);
            apb(1'b1, SRC_STAT_OFS, 32'h3c);
        end
    endtask : t_sources
    task automatic t_brown();
        @(posedge pclk) bod_stage1 <= 1'b1;
        #1 chk("bod_irq", brownout_detector_irq, 1'b1);
        apb(1'b0, SRC_STAT_OFS, 32'h0);
        chk("bod_stat", r[0], 1'b1);
        bod_stage1 <= 1'b0; bod_stage2 <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("bor_off", chip_reset_n, 1'b1);
        chk("bor_out", brownout_detector_reset, 1'b1);
        apb(1'b1, SRC_CTRL_OFS, 32'h1);
        #1 chk("bor_on", chip_reset_n, 1'b0);
        @(posedge pclk) bod_stage2 <= 1'b0;
        wait_lvl(chip_reset_n, 1'b1);
        apb(1'b0, SRC_STAT_OFS, 32'h0);
        chk("bor_seen", r[5], 1'b1);
        apb(1'b1, SRC_CTRL_OFS, 32'h0);
        apb(1'b1, SRC_STAT_OFS, 32'h3c);
    endtask : t_brown
    task automatic t_map_clk();
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, SRC_VMAP_OFS, v);
            apb(1'b0, SRC_VMAP_OFS, 32'h0);
            chk("vmap", r, (v == 3) ? 32'h2 : v);
        end
        apb(1'b0, 12'h01c, 32'h0);
        chk("unmapped_err", e, 1'b1);
        chk("unmapped_rd", r, 32'h0);
        apb(1'b1, SRC_CLK_OFS, 32'h8);
        #1 chk("con_alone", mul_connect, 1'b0);
        apb(1'b1, SRC_CLK_OFS, 32'hd);
        #1 chk("clk_set", {clk_source, mul_enable, mul_connect}, 4'h7);
        apb(1'b1, SRC_VMAP_OFS, 32'h1);
        ext_reset_n <= 1'b0;
        repeat (3) @(posedge pclk);
        ext_reset_n <= 1'b1;
        wait_lvl(chip_reset_n, 1'b1);
        chk("clk_rst", {clk_source, mul_enable, mul_connect}, 4'h0);
        chk("vmap_rst", vector_map, 2'h2);
    endtask : t_map_clk
    task automatic t_pd();
        wait_lvl(booting, 1'b0);
        apb(1'b1, SRC_WAKE_OFS, 32'h1);
        apb(1'b1, SRC_PD_OFS, 32'h1);
        #1 chk("pd_on", power_down, 1'b1);
        @(posedge pclk) ext_irq <= 4'h1;
        #1 chk("wakeup", wakeup, 1'b1);
        wait_lvl(power_down, 1'b0);
        @(posedge pclk) ext_irq <= 4'h0;
        chk("pd_off", power_down, 1'b0);
        repeat (WAKE_CYCLES + 4) @(posedge pclk);
        #1 chk("pd_keep", {chip_reset_n, booting}, 2'h2);
        wait_lvl(chip_reset_n, 1'b1);
    endtask : t_pd
    initial begin
        bad_count = 0; checks_done = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
        pwdata = 32'h0; ext_reset_n = 1'b1; wdt_reset = 1'b0; por_detect = 1'b0;
        osc_running = 1'b1; bod_stage1 = 1'b0; bod_stage2 = 1'b0; ext_irq = 4'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_boot();
        t_sources();
        t_brown();
        t_map_clk();
        t_pd();
        results();
    end
    // Hang guard well beyond the expected few hundred cycles
    initial begin
        #200000;
        bad_count++;
        results();
    end
endmodule : src_top_tb
bind src_top src_top_asserts #(.WAKE_CYCLES(WAKE_CYCLES), .NUM_EXTINT(NUM_EXTINT)) u_chk (
    .pclk, .presetn, .ext_reset_n, .wdt_reset, .por_detect, .osc_running, .bod_stage1,
    .bod_stage2, .ext_irq, .chip_reset_n, .brownout_detector_irq, .brownout_detector_reset,
    .wakeup, .boot_addr, .boot_bank, .boot_data_width, .boot_addr_lines, .vector_map,
    .mul_enable, .mul_connect, .power_down);
`default_nettype wire
